/* verilog/scq_pkg.sv */
// Purpose: constants and types of the sequencer trigger qualifier
// Assumes: one 250 MHz clock, registers over APB, byte offsets
// Notes:   all registers reset to zero except status, which reads not ready
// Operation
// - software picks the strobe from port bits 16 to 31
// - strobe edge is none, rising, falling or either
// - software picks the valid qualifier from port bits 16 to 31
// - qualifier polarity is none, low, high or either level
// - gating passes port and analog triggers only while trigger input 3 or 4 allows
// - analog trigger re-arms after moving hysteresis away; zero disables
// - hysteresis is absolute or percent of full scale, above 100 allowed
// - analog edge can be rising, falling or either
// - sticky flag shows an auxiliary trigger was detected
// - sticky flag shows triggers came from the parallel port
// - sequencer reports idle, running, waiting or not ready
// - counter shows current instruction position while running
// - cache holds 1024 instructions; size reported as a fraction
// - rerun restarts the program after each completion
// - command table upload state per core: none, done or error
// - one program line is one instruction, one counter step
// - analog trigger offers a level mode firing while beyond level
// - software force injects a trigger at once
package scq_pkg;
  localparam int         SCQ_AW          = 8;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SCQ_OFS_CTRL    = 8'h00;
  localparam logic [7:0] SCQ_OFS_PORT    = 8'h04;
  localparam logic [7:0] SCQ_OFS_ATRIG   = 8'h08;
  localparam logic [7:0] SCQ_OFS_LEVEL   = 8'h0C;
  localparam logic [7:0] SCQ_OFS_HYST    = 8'h10;
  localparam logic [7:0] SCQ_OFS_HPCT    = 8'h14;
  localparam logic [7:0] SCQ_OFS_FSCALE  = 8'h18;
  localparam logic [7:0] SCQ_OFS_LEN     = 8'h1C;
  localparam logic [7:0] SCQ_OFS_STATUS  = 8'h20;
  localparam logic [7:0] SCQ_OFS_COUNT   = 8'h24;
  localparam logic [7:0] SCQ_OFS_CTCLR   = 8'h28;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int         SCQ_CTRL_START  = 0;
  localparam int         SCQ_CTRL_RERUN  = 1;
  localparam int         SCQ_CTRL_GATE   = 2;
  localparam int         SCQ_CTRL_GSEL   = 3;
  localparam int         SCQ_CTRL_FORCE  = 4;
  localparam int         SCQ_CTRL_STOP   = 5;
  localparam int         SCQ_ST_AUX      = 4;
  localparam int         SCQ_ST_PORT     = 5;
  localparam int         SCQ_ST_CT       = 8;
  localparam int         SCQ_CNT_USE     = 16;
  localparam int         SCQ_PORT_BASE   = 16;
  localparam int         SCQ_CACHE_DEPTH = 1024;
  localparam int         SCQ_PCT_FULL    = 100;
  localparam logic [15:0] SCQ_RST_WORD   = 16'h0000;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SCQ_EDGE_NONE   = 2'h0; // level for analog
  localparam logic [1:0] SCQ_EDGE_RISE   = 2'h1;
  localparam logic [1:0] SCQ_EDGE_FALL   = 2'h2;
  localparam logic [1:0] SCQ_EDGE_BOTH   = 2'h3;
  localparam logic [1:0] SCQ_POL_NONE    = 2'h0;
  localparam logic [1:0] SCQ_POL_LOW     = 2'h1;
  localparam logic [1:0] SCQ_POL_HIGH    = 2'h2;
  localparam logic [1:0] SCQ_POL_BOTH    = 2'h3;
  localparam logic [1:0] SCQ_CT_NONE     = 2'h0;
  localparam logic [1:0] SCQ_CT_OK       = 2'h1;
  localparam logic [1:0] SCQ_CT_ERR      = 2'h2;
  typedef enum logic [3:0] {
    SCQ_NOTRDY = 4'h1,
    SCQ_IDLE   = 4'h2,
    SCQ_RUN    = 4'h4,
    SCQ_WAIT   = 4'h8
  } scq_seq_t;
endpackage : scq_pkg

/* verilog/scq_port_qual.sv */
`timescale 1ns/1ps
// Purpose: strobe and valid qualification on the parallel port
// Assumes: port bits synchronous to pclk
// Notes:   one cycle from sample to event
module scq_port_qual (
  input  wire logic        pclk,      // device clock
  input  wire logic        presetn,   // async reset, low
  input  wire logic [31:0] port_in,   // parallel digital port
  input  wire logic [3:0]  stb_idx,   // strobe bit minus 16
  input  wire logic [1:0]  stb_slope, // strobe edge select
  input  wire logic [3:0]  vld_idx,   // valid bit minus 16
  input  wire logic [1:0]  vld_pol,   // valid polarity
  output logic             port_evt   // qualified strobe pulse
);
  import scq_pkg::*;
  typedef struct packed {
    logic stb;
    logic prev;
    logic vld;
    logic evt;
  } scq_pq_t;
  scq_pq_t s, n;

  function automatic logic pick(input logic [31:0] p, input logic [3:0] i);
    pick = p[SCQ_PORT_BASE + int'(i)];
  endfunction : pick

  // sample, compare against previous sample, qualify
  always_comb begin
    logic rise;
    logic fall;
    logic ok;
    rise   = s.stb & ~s.prev;
    fall   = ~s.stb & s.prev;
    ok     = 1'b1;
    n      = s;
    n.stb  = pick(port_in, stb_idx);
    n.vld  = pick(port_in, vld_idx);
    n.prev = s.stb;
    unique case (vld_pol)
      SCQ_POL_LOW:  ok = ~s.vld;
      SCQ_POL_HIGH: ok = s.vld;
      default:      ok = 1'b1;
    endcase
    unique case (stb_slope)
      SCQ_EDGE_RISE: n.evt = rise & ok;
      SCQ_EDGE_FALL: n.evt = fall & ok;
      SCQ_EDGE_BOTH: n.evt = (rise | fall) & ok;
      default:       n.evt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign port_evt = s.evt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pol_high;
    (vld_pol == SCQ_POL_HIGH && !s.vld) |=> !s.evt;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("event with valid low");
  property p_no_slope;
    (stb_slope == SCQ_EDGE_NONE) |=> !s.evt;
  endproperty
  a_no_slope: assert property (p_no_slope) else $error("event with slope none");
endmodule : scq_port_qual

/* verilog/scq_analog_trig.sv */
`timescale 1ns/1ps
// Purpose: analog level trigger with edge select and hysteresis
// Assumes: sample is signed, synchronous to pclk
// Notes:   relative hysteresis is percent of full-scale codes
module scq_analog_trig (
  input  wire logic        pclk,    // device clock
  input  wire logic        presetn, // async reset, low
  input  wire logic [15:0] sample,  // signed input sample
  input  wire logic [15:0] level,   // signed trigger level
  input  wire logic [15:0] hyst,    // absolute hysteresis, codes
  input  wire logic [15:0] hpct,    // relative hysteresis, percent
  input  wire logic [15:0] fscale,  // full scale, codes
  input  wire logic [1:0]  slope,   // level, rise, fall, both
  input  wire logic        rel,     // relative mode
  output logic             fire     // trigger pulse
);
  import scq_pkg::*;
  typedef struct packed {
    logic [15:0] prev;
    logic        armed;
    logic        fire;
  } scq_at_t;
  scq_at_t s, n;

  // percent of full scale, clamped; values above 100 allowed
  function automatic logic [16:0] rel_h(input logic [15:0] f, input logic [15:0] p);
    logic [31:0] q;
    q = (32'(f) * 32'(p)) / 32'(SCQ_PCT_FULL);
    rel_h = (q > 32'h0001FFFF) ? 17'h1FFFF : q[16:0];
  endfunction : rel_h

  always_comb begin
    logic signed [18:0] x, p, lv, h;
    logic [16:0] he;
    logic hit, re;
    he  = rel ? rel_h(fscale, hpct) : {1'b0, hyst};
    x   = 19'(signed'(sample));
    p   = 19'(signed'(s.prev));
    lv  = 19'(signed'(level));
    h   = signed'({2'h0, he});
    hit = 1'b0;
    re  = 1'b0;
    unique case (slope)
      SCQ_EDGE_RISE: begin
        hit = (p < lv) && (x >= lv);
        re  = x <= lv - h;
      end
      SCQ_EDGE_FALL: begin
        hit = (p >= lv) && (x < lv);
        re  = x >= lv + h;
      end
      SCQ_EDGE_BOTH: begin
        hit = (p < lv) != (x < lv);
        re  = (x <= lv - h) || (x >= lv + h);
      end
      default: hit = x >= lv;
    endcase
    n      = s;
    n.prev = sample;
    n.fire = (slope == SCQ_EDGE_NONE) ? hit : hit & s.armed;
    if (he == 17'h0) begin
      n.armed = 1'b1;
    end else if (n.fire && slope != SCQ_EDGE_NONE) begin
      n.armed = 1'b0;
    end else begin
      n.armed = s.armed | re;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.armed <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign fire = s.fire;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_zero_hyst;
    (!rel && hyst == SCQ_RST_WORD) |=> s.armed;
  endproperty
  a_zero_hyst: assert property (p_zero_hyst) else $error("not armed at zero hyst");
endmodule : scq_analog_trig

/* verilog/scq_top.sv */
`timescale 1ns/1ps
// Purpose: trigger qualification and sequencer status, APB slave
// Assumes: one clock, port and trigger inputs synchronous to pclk
// Notes:   APB answers without wait states on every access
module scq_top #(
  parameter int NC = 1 // sequencer cores
) (
  input  wire logic                      pclk,       // device clock
  input  wire logic                      presetn,    // async reset, low
  input  wire logic [scq_pkg::SCQ_AW-1:0] paddr,     // APB address
  input  wire logic                      psel,       // APB select
  input  wire logic                      penable,    // APB enable
  input  wire logic                      pwrite,     // APB direction
  input  wire logic [31:0]               pwdata,     // APB write data
  output logic      [31:0]               prdata,     // APB read data
  output logic                           pready,     // APB ready
  output logic                           pslverr,    // APB error
  input  wire logic [31:0]               port_in,    // parallel digital port
  input  wire logic                      trig_in3,   // gating input 3
  input  wire logic                      trig_in4,   // gating input 4
  input  wire logic [15:0]               ana_sample, // analog trigger source
  input  wire logic                      instr_wait, // current instr waits
  input  wire logic [NC-1:0]             ct_ok,      // table upload done
  input  wire logic [NC-1:0]             ct_err,     // table upload failed
  output logic      [3:0]                seq_state,  // one-hot state
  output logic      [9:0]                seq_pc,     // instruction position
  output logic                           seq_trig,   // trigger to sequencer
  output logic                           aux_seen,   // analog trigger seen
  output logic                           port_seen   // port trigger seen
);
  import scq_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    scq_seq_t        st;
    logic [9:0]      pc;
    logic [10:0]     len;
    logic            rerun;
    logic            gate_en;
    logic            gate_sel;
    logic            start;
    logic            stop;
    logic            kick;
    logic [3:0]      stb_idx;
    logic [1:0]      stb_slope;
    logic [3:0]      vld_idx;
    logic [1:0]      vld_pol;
    logic [1:0]      a_slope;
    logic            a_rel;
    logic [15:0]     level;
    logic [15:0]     hyst;
    logic [15:0]     hpct;
    logic [15:0]     fscale;
    logic            aux_seen;
    logic            port_seen;
    logic [2*NC-1:0] ct;
    logic            trig;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } scq_top_t;
  scq_top_t s, n;

  logic port_evt;
  logic ana_evt;
  logic gate_ok;
  logic trig_evt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [SCQ_AW-1:0] a);
    mapped = (a == SCQ_OFS_CTRL)   || (a == SCQ_OFS_PORT)   ||
             (a == SCQ_OFS_ATRIG)  || (a == SCQ_OFS_LEVEL)  ||
             (a == SCQ_OFS_HYST)   || (a == SCQ_OFS_HPCT)   ||
             (a == SCQ_OFS_FSCALE) || (a == SCQ_OFS_LEN)    ||
             (a == SCQ_OFS_STATUS) || (a == SCQ_OFS_COUNT)  ||
             (a == SCQ_OFS_CTCLR);
  endfunction : mapped

  // program fits the instruction cache
  function automatic logic len_ok(input logic [10:0] l);
    len_ok = (l != 11'h0) && (int'(l) <= SCQ_CACHE_DEPTH);
  endfunction : len_ok

  // program size as a percentage of cache capacity
  function automatic logic [7:0] usage(input logic [10:0] l);
    logic [31:0] u;
    u = (32'(l) * 32'(SCQ_PCT_FULL)) / 32'(SCQ_CACHE_DEPTH);
    usage = u[7:0];
  endfunction : usage

  // ---------------------------------------------------------------
  // qualifiers
  // ---------------------------------------------------------------
  scq_port_qual u_port (
    .pclk      (pclk),
    .presetn   (presetn),
    .port_in   (port_in),
    .stb_idx   (s.stb_idx),
    .stb_slope (s.stb_slope),
    .vld_idx   (s.vld_idx),
    .vld_pol   (s.vld_pol),
    .port_evt  (port_evt)
  );

  scq_analog_trig u_ana (
    .pclk    (pclk),
    .presetn (presetn),
    .sample  (ana_sample),
    .level   (s.level),
    .hyst    (s.hyst),
    .hpct    (s.hpct),
    .fscale  (s.fscale),
    .slope   (s.a_slope),
    .rel     (s.a_rel),
    .fire    (ana_evt)
  );

  // gating and trigger merge; force bypasses the gate
  assign gate_ok  = ~s.gate_en | (s.gate_sel ? trig_in4 : trig_in3);
  assign trig_evt = ((port_evt | ana_evt) & gate_ok) | s.kick;

  // ---------------------------------------------------------------
  // next state: bus, flags, sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic        setup;
    logic        wr;
    logic        adv;
    logic        last;
    logic [31:0] rd;
    logic [2*NC-1:0] ct_clr;
    logic        clr_aux;
    logic        clr_port;
    setup    = psel & ~penable;
    wr       = psel & penable & s.pready & pwrite & ~s.pslverr;
    adv      = 1'b0;
    last     = (11'(s.pc) + 11'h1) >= s.len;
    rd       = 32'h0;
    ct_clr   = '0;
    clr_aux  = 1'b0;
    clr_port = 1'b0;
    n         = s;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.start   = 1'b0;
    n.stop    = 1'b0;
    n.kick    = 1'b0;
    n.trig    = trig_evt;
    // read data prepared in the setup cycle
    case (paddr)
      SCQ_OFS_CTRL: begin
        rd[SCQ_CTRL_RERUN] = s.rerun;
        rd[SCQ_CTRL_GATE]  = s.gate_en;
        rd[SCQ_CTRL_GSEL]  = s.gate_sel;
      end
      SCQ_OFS_PORT:   rd = {20'h0, s.vld_pol, s.vld_idx, s.stb_slope, s.stb_idx};
      SCQ_OFS_ATRIG:  rd = {29'h0, s.a_rel, s.a_slope};
      SCQ_OFS_LEVEL:  rd = {16'h0, s.level};
      SCQ_OFS_HYST:   rd = {16'h0, s.hyst};
      SCQ_OFS_HPCT:   rd = {16'h0, s.hpct};
      SCQ_OFS_FSCALE: rd = {16'h0, s.fscale};
      SCQ_OFS_LEN:    rd = {21'h0, s.len};
      SCQ_OFS_STATUS: begin
        rd[3:0]                  = s.st;
        rd[SCQ_ST_AUX]           = s.aux_seen;
        rd[SCQ_ST_PORT]          = s.port_seen;
        rd[SCQ_ST_CT +: 2*NC]    = s.ct;
      end
      SCQ_OFS_COUNT: begin
        rd[9:0]              = s.pc;
        rd[SCQ_CNT_USE +: 8] = usage(s.len);
      end
      default: rd = 32'h0;
    endcase
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = ~mapped(paddr);
      n.prdata  = pwrite ? 32'h0 : rd;
    end
    // writes take effect at the completing edge
    if (wr) begin
      case (paddr)
        SCQ_OFS_CTRL: begin
          n.start    = pwdata[SCQ_CTRL_START];
          n.rerun    = pwdata[SCQ_CTRL_RERUN];
          n.gate_en  = pwdata[SCQ_CTRL_GATE];
          n.gate_sel = pwdata[SCQ_CTRL_GSEL];
          n.kick     = pwdata[SCQ_CTRL_FORCE];
          n.stop     = pwdata[SCQ_CTRL_STOP];
        end
        SCQ_OFS_PORT: begin
          n.stb_idx   = pwdata[3:0];
          n.stb_slope = pwdata[5:4];
          n.vld_idx   = pwdata[9:6];
          n.vld_pol   = pwdata[11:10];
        end
        SCQ_OFS_ATRIG: begin
          n.a_slope = pwdata[1:0];
          n.a_rel   = pwdata[2];
        end
        SCQ_OFS_LEVEL:  n.level  = pwdata[15:0];
        SCQ_OFS_HYST:   n.hyst   = pwdata[15:0];
        SCQ_OFS_HPCT:   n.hpct   = pwdata[15:0];
        SCQ_OFS_FSCALE: n.fscale = pwdata[15:0];
        SCQ_OFS_STATUS: begin
          clr_aux  = pwdata[SCQ_ST_AUX];
          clr_port = pwdata[SCQ_ST_PORT];
        end
        SCQ_OFS_CTCLR: begin
          for (int c = 0; c < NC; c++) begin
            ct_clr[2*c +: 2] = {2{pwdata[c]}};
          end
        end
        default: n.level = s.level;
      endcase
    end
    // sticky flags, a new event wins over a clear
    n.aux_seen  = (s.aux_seen & ~clr_aux) | ana_evt;
    n.port_seen = (s.port_seen & ~clr_port) | (port_evt & gate_ok);
    for (int c = 0; c < NC; c++) begin
      if (ct_err[c]) begin
        n.ct[2*c +: 2] = SCQ_CT_ERR;
      end else if (ct_ok[c]) begin
        n.ct[2*c +: 2] = SCQ_CT_OK;
      end else begin
        n.ct[2*c +: 2] = s.ct[2*c +: 2] & ~ct_clr[2*c +: 2];
      end
    end
    // sequencer walk, one instruction per step
    unique case (s.st)
      SCQ_NOTRDY: begin
        if (len_ok(s.len)) begin
          n.st = SCQ_IDLE;
        end
      end
      SCQ_IDLE: begin
        if (s.start) begin
          n.st = SCQ_RUN;
          n.pc = 10'h0;
        end
      end
      SCQ_RUN: begin
        if (instr_wait) begin
          n.st = SCQ_WAIT;
        end else begin
          adv = 1'b1;
        end
      end
      SCQ_WAIT: begin
        adv = trig_evt;
      end
      default: n.st = SCQ_NOTRDY;
    endcase
    if (adv) begin
      if (last && s.rerun) begin
        n.st = SCQ_RUN;
        n.pc = 10'h0;
      end else if (last) begin
        n.st = SCQ_IDLE;
      end else begin
        n.st = SCQ_RUN;
        n.pc = s.pc + 10'h1;
      end
    end
    if (s.stop && (s.st == SCQ_RUN || s.st == SCQ_WAIT)) begin
      n.st = SCQ_IDLE;
    end
    // a new program length forces a reload check
    if (wr && paddr == SCQ_OFS_LEN) begin
      n.len = pwdata[10:0];
      n.st  = SCQ_NOTRDY;
      n.pc  = 10'h0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s    <= '0;
      s.st <= SCQ_NOTRDY;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state flops
  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign seq_state = s.st;
  assign seq_pc    = s.pc;
  assign seq_trig  = s.trig;
  assign aux_seen  = s.aux_seen;
  assign port_seen = s.port_seen;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_gate_block;
    (s.gate_en && !(s.gate_sel ? trig_in4 : trig_in3) && !s.kick) |=> !s.trig;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("trigger passed gate");

  property p_force;
    s.kick |=> s.trig;
  endproperty
  a_force: assert property (p_force) else $error("force lost");

  property p_aux;
    ana_evt |=> s.aux_seen;
  endproperty
  a_aux: assert property (p_aux) else $error("aux flag not set");

  property p_port;
    (port_evt && gate_ok) |=> s.port_seen;
  endproperty
  a_port: assert property (p_port) else $error("port flag not set");

  property p_onehot;
    $onehot(s.st);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state not one-hot");

  property p_step;
    (s.st == SCQ_RUN && !instr_wait && !s.stop && !psel &&
     (11'(s.pc) + 11'h1) < s.len) |=> s.pc == $past(s.pc) + 10'h1;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  property p_cache;
    (s.st == SCQ_IDLE || s.st == SCQ_RUN) |-> len_ok(s.len);
  endproperty
  a_cache: assert property (p_cache) else $error("runs with bad length");

  property p_rerun;
    (s.st == SCQ_RUN && !instr_wait && !s.stop && !psel && s.rerun &&
     (11'(s.pc) + 11'h1) >= s.len) |=> (s.st == SCQ_RUN && s.pc == 10'h0);
  endproperty
  a_rerun: assert property (p_rerun) else $error("rerun did not restart");

  property p_ct_err;
    ct_err[0] |=> s.ct[1:0] == SCQ_CT_ERR;
  endproperty
  a_ct_err: assert property (p_ct_err) else $error("upload error not shown");

  property p_wait_hold;
    (s.st == SCQ_WAIT && !trig_evt && !s.stop && !psel) |=> s.st == SCQ_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait untriggered");

  c_release: cover property (s.st == SCQ_WAIT ##1 s.st == SCQ_RUN);
  c_rerun:   cover property (s.st == SCQ_RUN && s.rerun ##1 s.pc == 10'h0);
  c_portev:  cover property (port_evt ##1 s.port_seen);
endmodule : scq_top

/* verif/scq_ctrl_model.sv */
`timescale 1ns/1ps
// Purpose: external controller driving codewords on the parallel port
// Assumes: caller picks strobe bit, valid bit and valid level
// Notes:   codeword and valid are inverted once a frame is released
module scq_ctrl_model (
  input  wire logic        pclk,    // device clock
  output logic      [31:0] port_out // parallel digital port
);
  initial port_out = 32'h0000_0000;
  // one frame: codeword with valid, then a strobe flip, then release
  task automatic send(input logic [4:0] sb, input logic [4:0] vb, input logic vl);
    logic [31:0] w;
    w = port_out;
    w[15:0] = 16'hA5C3;
    w[vb] = vl;
    @(posedge pclk) port_out <= w;
    w[sb] = ~w[sb];
    @(posedge pclk) port_out <= w;
    repeat (3) @(posedge pclk);
    w[15:0] = ~w[15:0];
    w[vb] = ~vl;
    port_out <= w;
  endtask : send
endmodule : scq_ctrl_model

/* verif/test_sequencer_trigger_qualifier.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench for the trigger qualifier
// Assumes: controller model drives the parallel port
// Notes:   expectations follow the register map of scq_pkg
module test_sequencer_trigger_qualifier;
  import scq_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, port_in, rd;
  logic        trig_in3 = 0, trig_in4 = 0, instr_wait = 1, seq_trig, aux_seen, port_seen;
  logic [15:0] ana_sample = 16'h8000;
  logic [0:0]  ct_err = 1'b0;
  logic [3:0]  seq_state;
  logic [9:0]  seq_pc;
  int          miscompares = 0, n_compared = 0, npc = 0, lvl = 0;
  scq_top #(.NC(1)) DUT (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .port_in, .trig_in3, .trig_in4, .ana_sample, .instr_wait,
    .ct_ok(1'b0), .ct_err, .seq_state, .seq_pc, .seq_trig, .aux_seen, .port_seen
  );
  scq_ctrl_model ctl (.pclk, .port_out(port_in));
  // 250 MHz clock
  always #2 pclk = ~pclk;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // one APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // one port frame, then the expected position
  task automatic tx(input logic f);
    ctl.send(5'd21, 5'd18, 1'b1);
    repeat (2) @(posedge pclk);
    npc += int'(f);
    chk("seq_pc", npc, seq_pc);
  endtask : tx
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    chk("reset state", 4'h1, seq_state);
    apb(0, SCQ_OFS_STATUS, 0);
    chk("status", 32'h1, rd);
    apb(0, 8'h2C, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1, SCQ_OFS_LEN, 512);
    apb(1, SCQ_OFS_CTRL, 1);
    repeat (3) @(posedge pclk);
    chk("wait state", SCQ_WAIT, seq_state);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1, SCQ_OFS_PORT, 32'(5 | s << 4 | 2 << 6 | p << 10));
        lvl ^= 1;
        tx((s == 3 || (s == 1 && lvl == 1) || (s == 2 && lvl == 0)) && p != 1);
      end
    end
    chk("port seen", 1, port_seen);
    apb(0, SCQ_OFS_PORT, 0);
    chk("port cfg", 32'hCB5, rd);
    for (int i = 0; i < 4; i++) begin
      trig_in3 <= (i != 0);
      trig_in4 <= (i == 3);
      apb(1, SCQ_OFS_CTRL, i < 2 ? 4 : 12);
      tx(i[0]);
    end
    trig_in4 <= 0;
    apb(1, SCQ_OFS_CTRL, 32'h1C);
    repeat (2) @(posedge pclk);
    chk("force trig", 1, seq_trig);
    @(posedge pclk);
    npc++;
    chk("force pc", npc, seq_pc);
    apb(0, SCQ_OFS_COUNT, 0);
    chk("count", 32'(50 << 16 | npc), rd);
    apb(1, SCQ_OFS_LEVEL, 32'h100);
    apb(1, SCQ_OFS_HYST, 32'h10);
    apb(1, SCQ_OFS_ATRIG, 1);
    ana_sample <= 16'h0200;
    repeat (3) @(posedge pclk);
    chk("aux seen", 1, aux_seen);
    ct_err <= 1;
    @(posedge pclk) ct_err <= 0;
    apb(1, SCQ_OFS_STATUS, 32'h30);
    ana_sample <= 16'h00F8;
    repeat (2) @(posedge pclk) ana_sample <= 16'h0200;
    repeat (3) @(posedge pclk);
    chk("no rearm", 0, aux_seen);
    ana_sample <= 16'h00F0;
    repeat (2) @(posedge pclk) ana_sample <= 16'h0200;
    repeat (3) @(posedge pclk);
    chk("rearm", 1, aux_seen);
    apb(0, SCQ_OFS_STATUS, 0);
    chk("status err", 32'h218, rd);
    apb(1, SCQ_OFS_CTCLR, 1);
    apb(0, SCQ_OFS_STATUS, 0);
    chk("status clr", 32'h18, rd);
    ana_sample <= 16'h00F0;
    apb(1, SCQ_OFS_ATRIG, 0);
    apb(1, SCQ_OFS_STATUS, 32'h10);
    @(posedge pclk);
    chk("level idle", 0, aux_seen);
    ana_sample <= 16'h0200;
    repeat (3) @(posedge pclk);
    chk("level fire", 1, aux_seen);
    apb(1, SCQ_OFS_LEN, 2);
    instr_wait <= 0;
    apb(1, SCQ_OFS_CTRL, 3);
    repeat (4) @(posedge pclk);
    chk("rerun state", SCQ_RUN, seq_state);
    chk("rerun pc", 0, seq_pc);
    end_of_test();
  end
endmodule : test_sequencer_trigger_qualifier
